// ### rtl/spiop_pkg.sv
package spiop_pkg;
  localparam int SPIOP_WIDTH = 16;
  localparam int SPIOP_CN_COUNT = 24;
  localparam int SPIOP_CN_HALF = 16;
  localparam logic [15:0] SPIOP_DIR_RST = 16'hffff;
  localparam logic [15:0] SPIOP_LAT_RST = 16'h0000;
  localparam logic [15:0] SPIOP_ODC_RST = 16'h0000;
  localparam logic [15:0] SPIOP_PCFG_RST = 16'h0000;
  localparam logic [15:0] SPIOP_CNEN_RST = 16'h0000;
  localparam logic [15:0] SPIOP_CNPU_RST = 16'h0000;
  typedef enum logic [2:0]
  {
    SPIOP_CMD_NONE = 3'h0,
    SPIOP_CMD_DIR = 3'h1,
    SPIOP_CMD_LAT = 3'h2,
    SPIOP_CMD_PORT = 3'h3,
    SPIOP_CMD_ODC = 3'h4
  } spiop_cmd_t;
endpackage

// ### rtl/spiop_port.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1: Active peripheral takes the pin's output driver
// RL2: Idle enabled peripheral leaves pin to port
// RL3: Port output never loops into peripheral input
// RL4: Direction bit one is input, zero output
// RL5: Reset makes every pin an input
// RL6: Latch read returns latch, write updates latch
// RL7: Port read returns pins, write updates latch
// RL8: Unimplemented bits read zero everywhere
// RL9: Open-drain bit makes port-driven output drive low only
// RL10: Cleared config bit means analog, reset analog
// RL11: Either converter's cleared bit makes pin analog
// RL12: Analog pins read zero from port register
// RL13: Disabled converter forces its pins digital
// RL14: Software sets analog pins as inputs
// RL15: Software waits one cycle before reading port
// RL16: Twenty-four change inputs can request interrupt
// RL17: Change detection keeps working during sleep
// RL18: Enable bit lets a pin's changes interrupt
// RL19: Each change pin has enabled weak pull-up
// RL20: Software drops pull-up on digital outputs
// RL21: Enabled pin differing from sample sets flag
module spiop_port
  import spiop_pkg::*;
#(
  parameter int WIDTH = SPIOP_WIDTH,
  parameter logic [15:0] IMPL_MASK = 16'hffff,
  parameter logic [15:0] ANALOG_MASK = 16'h00ff,
  parameter int CN_COUNT = SPIOP_CN_COUNT
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sleep_mode,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic pcfg1_wr,
  input wire logic [15:0] pcfg1_data,
  input wire logic pcfg2_wr,
  input wire logic [15:0] pcfg2_data,
  input wire logic conv1_disable,
  input wire logic second_converter_disable,
  input wire logic change_int_enable_1_wr,
  input wire logic [15:0] change_int_enable_1_data,
  input wire logic change_int_enable_2_wr,
  input wire logic [15:0] change_int_enable_2_data,
  input wire logic weak_pullup_enable_1_wr,
  input wire logic [15:0] weak_pullup_enable_1_data,
  input wire logic weak_pullup_enable_2_wr,
  input wire logic [15:0] weak_pullup_enable_2_data,
  input wire logic cn_flag_clr,
  input wire logic [15:0] pin_in,
  input wire logic [15:0] periph_active,
  input wire logic [15:0] periph_out,
  input wire logic [23:0] cn_pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] periph_in,
  output logic [15:0] pin_direction_reg,
  output logic [15:0] output_latch_reg,
  output logic [15:0] pin_level_reg,
  output logic [15:0] open_drain_select_reg,
  output logic [15:0] analog_pins,
  output logic [23:0] weak_pullup_en,
  output logic cn_flag
);
  initial
  begin
    if (WIDTH != 16)
      $error("spiop_port: WIDTH must be 16");
    if (CN_COUNT < 1 || CN_COUNT > 24)
      $error("spiop_port: CN_COUNT must lie in 1 to 24");
    if ((ANALOG_MASK & ~IMPL_MASK) != 16'h0000)
      $error("spiop_port: ANALOG_MASK names unimplemented pins");
    if (IMPL_MASK == 16'h0000)
      $error("spiop_port: IMPL_MASK leaves no pins");
  end

  // Unimplemented bits never leave the block
  function automatic logic [15:0] impl_bits(input logic [15:0] v);
    impl_bits = v & IMPL_MASK;
  endfunction

  // A disabled converter claims no pins whatever its config holds
  function automatic logic [15:0] conv_claims(input logic off, input logic [15:0] cfg);
    conv_claims = off ? 16'h0000 : ~cfg;
  endfunction

  // Change inputs 23:16 live in the low byte of the second register
  function automatic logic [23:0] cn_join(input logic [15:0] hi, input logic [15:0] lo);
    cn_join = {hi[7:0], lo};
  endfunction

  logic [15:0] dir_ff;
  logic [15:0] lat_ff;
  logic [15:0] odc_ff;
  logic [15:0] pcfg1_ff;
  logic [15:0] pcfg2_ff;
  logic [15:0] change_int_enable_1_ff;
  logic [15:0] change_int_enable_2_ff;
  logic [15:0] weak_pullup_enable_1_ff;
  logic [15:0] weak_pullup_enable_2_ff;
  logic [23:0] cn_prev_ff;
  logic cn_primed_ff;
  logic cn_flag_ff;
  logic [15:0] nxt_analog;
  logic [15:0] nxt_level;
  logic [15:0] nxt_drv;
  logic [15:0] nxt_val;
  logic [15:0] nxt_oe;
  logic [15:0] nxt_out;
  logic [23:0] cn_mask;
  logic [23:0] cn_en;
  logic cn_hit;
  logic [15:0] nxt_periph;
  logic [23:0] cn_diff;

  // One process per register, except that both config registers share one; a write to the port lands in the latch
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      dir_ff <= SPIOP_DIR_RST; // RL5
    else if (wr_en && wr_sel == SPIOP_CMD_DIR)
      dir_ff <= wr_data; // RL4
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      lat_ff <= SPIOP_LAT_RST;
    else if (wr_en && wr_sel == SPIOP_CMD_LAT)
      lat_ff <= wr_data; // RL6
    else if (wr_en && wr_sel == SPIOP_CMD_PORT)
      lat_ff <= wr_data; // RL7
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      odc_ff <= SPIOP_ODC_RST;
    else if (wr_en && wr_sel == SPIOP_CMD_ODC)
      odc_ff <= wr_data; // RL9
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pcfg1_ff <= SPIOP_PCFG_RST; // RL10
      pcfg2_ff <= SPIOP_PCFG_RST;
    end
    else
    begin
      if (pcfg1_wr)
        pcfg1_ff <= pcfg1_data;
      if (pcfg2_wr)
        pcfg2_ff <= pcfg2_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      change_int_enable_1_ff <= SPIOP_CNEN_RST;
    else if (change_int_enable_1_wr)
      change_int_enable_1_ff <= change_int_enable_1_data; // RL18
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      change_int_enable_2_ff <= SPIOP_CNEN_RST;
    else if (change_int_enable_2_wr)
      change_int_enable_2_ff <= change_int_enable_2_data; // RL18
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      weak_pullup_enable_1_ff <= SPIOP_CNPU_RST;
    else if (weak_pullup_enable_1_wr)
      weak_pullup_enable_1_ff <= weak_pullup_enable_1_data; // RL19
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      weak_pullup_enable_2_ff <= SPIOP_CNPU_RST;
    else if (weak_pullup_enable_2_wr)
      weak_pullup_enable_2_ff <= weak_pullup_enable_2_data; // RL19
  end

  // Pin muxing and analog selection
  always_comb
  begin
    nxt_analog = impl_bits(ANALOG_MASK & (conv_claims(conv1_disable, pcfg1_ff) // RL10 RL13
      | conv_claims(second_converter_disable, pcfg2_ff))); // RL11 RL13
    nxt_level = impl_bits(pin_in & ~nxt_analog); // RL12 RL8
    // Peripheral owns the driver when active, else the port does
    nxt_val = (periph_active & periph_out) | (~periph_active & lat_ff); // RL1 RL2
    nxt_drv = periph_active | ~dir_ff; // RL1 RL2 RL4
    // Open drain, port-driven pins only: drive only a low level, release for a high
    nxt_oe = impl_bits(nxt_drv & ~(odc_ff & ~periph_active & nxt_val)); // RL9
    nxt_out = impl_bits(nxt_val & ~(odc_ff & ~periph_active)); // RL9
    // While the port drives a pin the peripheral sees zero, not our own data
    nxt_periph = impl_bits(pin_in & ~(~dir_ff & ~periph_active) & ~nxt_analog); // RL3
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= 16'h0000;
      pin_oe <= 16'h0000;
      periph_in <= 16'h0000;
    end
    else
    begin
      pin_out <= nxt_out;
      pin_oe <= nxt_oe;
      periph_in <= nxt_periph; // RL3
    end
  end

  // Readbacks cost a cycle of latency but keep every output on a flop
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_direction_reg <= 16'h0000;
      output_latch_reg <= 16'h0000;
      open_drain_select_reg <= 16'h0000;
    end
    else
    begin
      pin_direction_reg <= impl_bits(dir_ff); // RL8
      output_latch_reg <= impl_bits(lat_ff); // RL6 RL8
      open_drain_select_reg <= impl_bits(odc_ff);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_level_reg <= 16'h0000;
      analog_pins <= 16'h0000;
    end
    else
    begin
      pin_level_reg <= nxt_level; // RL7 RL12
      analog_pins <= nxt_analog;
    end
  end

  // Change notification
  always_comb
  begin
    cn_mask = (CN_COUNT >= 24) ? 24'hffffff : ((24'h000001 << CN_COUNT) - 24'h000001);
    cn_en = cn_join(change_int_enable_2_ff, change_int_enable_1_ff) & cn_mask; // RL18
    cn_diff = (cn_pin_in ^ cn_prev_ff) & cn_en; // RL21
    cn_hit = cn_primed_ff && cn_diff != 24'h000000; // RL21
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      weak_pullup_en <= 24'h000000;
    else
      weak_pullup_en <= cn_join(weak_pullup_enable_2_ff, weak_pullup_enable_1_ff) & cn_mask; // RL19
  end

  // Sampled every cycle irrespective of sleep_mode; only the core clock stops in sleep
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cn_prev_ff <= 24'h000000;
      cn_primed_ff <= 1'b0;
    end
    else
    begin
      cn_prev_ff <= cn_pin_in; // RL17
      cn_primed_ff <= 1'b1;
    end
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      cn_flag_ff <= 1'b0;
    else if (cn_hit)
      cn_flag_ff <= 1'b1; // RL16 RL21
    else if (cn_flag_clr)
      cn_flag_ff <= 1'b0;
  end

  // The flag pin is the flag flop itself, so a clear shows on the next cycle
  assign cn_flag = cn_flag_ff;
endmodule
`default_nettype wire

// ### dv/spiop_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
module spiop_pins_model
(
  input wire logic [15:0] ext_val,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  output logic [15:0] pin_in
);
  // Outside world always drives the pad, so a released pin shows ext_val
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// ### dv/spiop_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spiop_monitor
#(
  parameter logic [15:0] IMPL_MASK = 16'hffff,
  parameter logic [15:0] ANALOG_MASK = 16'h00ff
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [15:0] wr_data,
  input wire logic cn_flag_clr,
  input wire logic [23:0] cn_pin_in,
  input wire logic [15:0] pin_direction_reg,
  input wire logic [15:0] output_latch_reg,
  input wire logic [15:0] pin_level_reg,
  input wire logic [15:0] analog_pins,
  input wire logic cn_flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_dir_reset: assert property ($rose(reset_n) |-> ##1 pin_direction_reg == IMPL_MASK)
    else $error("dir not input");
  a_dir_wr: assert property (wr_en && wr_sel == 3'h1 |->
    ##2 pin_direction_reg == ($past(wr_data, 2) & IMPL_MASK)) else $error("dir write");
  a_latch_wr: assert property (wr_en && wr_sel inside {3'h2, 3'h3} |->
    ##2 output_latch_reg == ($past(wr_data, 2) & IMPL_MASK)) else $error("latch write");
  a_unimpl_zero: assert property (((pin_direction_reg | output_latch_reg |
    pin_level_reg) & ~IMPL_MASK) == 16'h0000) else $error("unimpl bit");
  a_analog_zero: assert property (($past(analog_pins) & analog_pins &
    pin_level_reg) == 16'h0000) else $error("analog read");
  a_analog_mask: assert property ((analog_pins & ~ANALOG_MASK) == 16'h0000)
    else $error("analog mask");
  a_flag_hold: assert property (cn_flag && !cn_flag_clr |=> cn_flag)
    else $error("flag lost");
  a_flag_cause: assert property ($rose(cn_flag) |-> $past(cn_pin_in) !=
    $past(cn_pin_in, 2) || $past(cn_pin_in, 2) != $past(cn_pin_in, 3)) else $error("flag");
endmodule
bind spiop_port spiop_monitor #(.IMPL_MASK(IMPL_MASK), .ANALOG_MASK(ANALOG_MASK)) u_mon (.*);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import spiop_pkg::*;
;
  localparam logic [15:0] IM = 16'h7fff;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sleep_mode, conv1_disable, second_converter_disable, cn_flag;
  logic [2:0] wr_sel;
  logic [7:0] st;
  logic [15:0] wd, periph_active, periph_out, ext_val, pin_in, pin_out, pin_oe, periph_in;
  logic [15:0] pin_direction_reg, output_latch_reg, pin_level_reg, open_drain_select_reg;
  logic [15:0] analog_pins, an, dv, oe, pn;
  logic [15:0] m [11];
  logic [23:0] cn_pin_in, weak_pullup_en, en;
  wire logic wr_en = st[0], pcfg1_wr = st[1], pcfg2_wr = st[2], change_int_enable_1_wr = st[3];
  wire logic change_int_enable_2_wr = st[4], weak_pullup_enable_1_wr = st[5], weak_pullup_enable_2_wr = st[6], cn_flag_clr = st[7];
  wire logic [15:0] wr_data = wd, pcfg1_data = wd, pcfg2_data = wd, change_int_enable_1_data = wd;
  wire logic [15:0] change_int_enable_2_data = wd, weak_pullup_enable_1_data = wd, weak_pullup_enable_2_data = wd;
  int errors = 0;
  int tests_run = 0;
  int seed = 95;
  int cyc = 0;
  spiop_port #(.IMPL_MASK(IM)) u_spiop_port (.*);
  spiop_pins_model u_spiop_pins_model (.*);
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (++cyc == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Codes 0-3 go through wr_sel, 4-10 each own a strobe bit
  task automatic w(input int k, input logic [15:0] d);
    @(posedge ref_clk);
    st <= 8'(1 << (k < 4 ? 0 : k - 3));
    wr_sel <= 3'(k + 1);
    wd <= d;
    m[k == 2 ? 1 : k] = d;
    @(posedge ref_clk);
    st <= 8'h00;
  endtask
  task automatic chk();
    repeat (4) @(posedge ref_clk);
    an = conv1_disable ? 16'hffff : m[4];
    an = 16'h00ff & ~(an & (second_converter_disable ? 16'hffff : m[5]));
    dv = IM & ~periph_active & ~m[0] & ~(m[3] & m[1]);
    oe = periph_active | dv;
    pn = (oe & ((periph_active & periph_out) | (dv & m[1]))) | (~oe & ext_val);
    cmp("dir", m[0] & IM, pin_direction_reg);
    cmp("lat", m[1] & IM, output_latch_reg);
    cmp("odc", m[3] & IM, open_drain_select_reg);
    cmp("oe", oe, pin_oe);
    cmp("out", pn & oe, pin_out & pin_oe);
    cmp("ana", an, analog_pins);
    cmp("lvl", pn & ~an & IM, pin_level_reg);
    cmp("per", pn & ~(~m[0] & ~periph_active) & ~an & IM, periph_in);
    cmp("pu", {m[9][7:0], m[8]}, weak_pullup_en);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    st = 8'h00;
    wd = 16'h0000;
    wr_sel = 3'h0;
    {sleep_mode, conv1_disable, second_converter_disable} = 3'h0;
    {periph_active, periph_out, cn_pin_in} = 56'h0;
    ext_val = 16'h5a3c;
    m = '{default: 16'h0000};
    m[0] = SPIOP_DIR_RST;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    chk();
    for (int i = 0; i < 20; i++)
    begin
      for (int k = 4; k < 10; k++)
        w(k, 16'($random(seed)));
      for (int k = 1; k < 4; k++)
        w(k, 16'($random(seed)));
      w(0, 16'($random(seed)) | (~(m[4] & m[5]) & 16'h00ff));
      periph_active <= 16'($random(seed)) & IM;
      periph_out <= 16'($random(seed));
      ext_val <= 16'($random(seed));
      {sleep_mode, conv1_disable, second_converter_disable} <= 3'($random(seed));
      chk();
    end
    en = {m[7][7:0], m[6]};
    for (int i = 0; i < 24; i++)
    begin
      w(10, 16'h0000);
      repeat (3) @(posedge ref_clk);
      cn_pin_in[i] <= ~cn_pin_in[i];
      sleep_mode <= i[0];
      repeat (3) @(posedge ref_clk);
      cmp("cn", 24'(en[i]), 24'(cn_flag));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
